// File: ctd_pkg.sv
package ctd_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_CONFIG = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_MASK = 12'h008;
    localparam logic [11:0] OFS_BUF_CMD = 12'h00c;
    localparam logic [11:0] OFS_BUF_STATE = 12'h010;
    localparam logic [11:0] OFS_EVENT = 12'h014;
    // Config bits, then event register status bits
    localparam int CFG_OFF = 0;
    localparam int CFG_FRZ = 1;
    localparam int ST_LPACK = 2;
    localparam int ST_FRZACK = 3;
    localparam int ST_CLKREQ = 4;
    // Command field layout: [1:0] op, [7:4] buffer, [11:8] code
    localparam int CMD_OP_LO = 0;
    localparam int CMD_BUF_LO = 4;
    localparam int CMD_CODE_LO = 8;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_ABORT = 2'h2;
    localparam logic [1:0] OP_DEACT = 2'h3;
    localparam logic [3:0] CODE_INACTIVE = 4'h8;
    localparam logic [3:0] CODE_ABORT = 4'h9;
    localparam logic [3:0] CODE_TX_DATA = 4'hc;
    // Interrupt status bits
    localparam int IRQ_TXDONE = 0;
    localparam int IRQ_LPENTER = 1;
    localparam int IRQ_LPEXIT = 2;
    localparam int IRQ_W = 3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        CTD_RUN = 2'b00,
        CTD_REQ = 2'b01,
        CTD_OFF = 2'b11,
        CTD_WAKE = 2'b10
    } ctd_pwr_t;

    typedef struct packed {
        logic valid;
        logic [3:0] buf_idx;
    } ctd_txdone_t;
endpackage

// File: ctd_ctrl.sv
`timescale 1ns/100ps
module ctd_ctrl import ctd_pkg::*; #(
    parameter int NBUF = 16
) (
    input wire logic i_mclk, // System clock
    input wire logic i_rst_n, // Async reset, active low
    input wire logic i_hsel, // AHB select
    input wire logic [11:0] i_haddr, // AHB address
    input wire logic [1:0] i_htrans, // AHB transfer type
    input wire logic i_hwrite, // AHB write
    input wire logic [2:0] i_hsize, // AHB size
    input wire logic [31:0] i_hwdata, // AHB write data
    input wire logic i_hready, // AHB ready in
    output logic [31:0] o_hrdata, // AHB read data
    output logic o_hreadyout, // AHB ready out
    output logic o_hresp, // AHB response
    input wire logic i_clk_stopped, // Engine clocks halted, async
    input wire logic i_tx_done, // Transmission finished, from engine
    input wire logic [3:0] i_tx_buf, // Buffer that finished
    output logic o_clk_stop_req, // Request clocks off
    output logic o_irq // Interrupt, active high
);
    logic [31:0] cfg, mask, irq_st;
    logic [3:0] code [NBUF];
    logic [NBUF-1:0] abort_pend, deact;
    logic [3:0] last_done;
    ctd_pwr_t pwr, next_pwr;
    logic stop_s1, stop_s2, lp_ack, freeze_acknowledge;
    logic ph_wr;
    logic [11:0] ph_addr;

    wire addr_ok = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
    wire wr = ph_wr;
    wire [1:0] op = i_hwdata[CMD_OP_LO +: 2];
    wire [3:0] cbuf = i_hwdata[CMD_BUF_LO +: 4];
    wire [3:0] ccode = i_hwdata[CMD_CODE_LO +: 4];
    wire cmd_wr = wr && ph_addr == OFS_BUF_CMD;
    wire cfg_wr = wr && ph_addr == OFS_CONFIG;
    wire off_bit = cfg[CFG_OFF];
    ctd_txdone_t done;
    assign done.valid = i_tx_done;
    assign done.buf_idx = i_tx_buf;
    // Transmit-done event and last_done update only for buffers not deactivated
    wire done_rep = done.valid && !deact[done.buf_idx];
    wire [IRQ_W-1:0] ev = {pwr == CTD_WAKE && !stop_s2,
                           pwr == CTD_REQ && stop_s2, done_rep};

    function automatic logic [31:0] rd_mux(input logic [11:0] a);
        case (a)
            OFS_CONFIG: rd_mux = cfg;
            OFS_STATUS: rd_mux = irq_st;
            OFS_MASK: rd_mux = mask;
            OFS_BUF_STATE: rd_mux = {{(32-NBUF){1'b0}}, abort_pend};
            OFS_EVENT: rd_mux = {27'h0, o_clk_stop_req, freeze_acknowledge, lp_ack,
                                  1'b0, 1'b0} | {28'h0, last_done};
            default: rd_mux = 32'h0;
        endcase
    endfunction

    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_irq = |(irq_st[IRQ_W-1:0] & mask[IRQ_W-1:0]);
    assign o_clk_stop_req = pwr == CTD_REQ || pwr == CTD_OFF;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph_wr <= 1'b0;
            ph_addr <= 12'h0;
            o_hrdata <= 32'h0;
        end else begin
            ph_wr <= addr_ok && i_hwrite;
            ph_addr <= i_haddr;
            if (addr_ok && !i_hwrite) begin
                o_hrdata <= rd_mux(i_haddr);
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stop_s1 <= 1'b0;
            stop_s2 <= 1'b0;
        end else begin
            stop_s1 <= i_clk_stopped;
            stop_s2 <= stop_s1;
        end
    end

    always_comb begin
        next_pwr = pwr;
        case (pwr)
            CTD_RUN: if (off_bit) next_pwr = CTD_REQ;
            CTD_REQ: if (stop_s2) next_pwr = CTD_OFF;
                else if (!off_bit) next_pwr = CTD_RUN;
            CTD_OFF: if (!off_bit) next_pwr = CTD_WAKE;
            CTD_WAKE: if (!stop_s2) next_pwr = CTD_RUN;
            default: next_pwr = CTD_RUN;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwr <= CTD_RUN;
            cfg <= 32'h0;
            mask <= 32'h0;
            irq_st <= 32'h0;
            lp_ack <= 1'b0;
            freeze_acknowledge <= 1'b0;
            last_done <= 4'h0;
        end else begin
            pwr <= next_pwr;
            if (cfg_wr) cfg <= {30'h0, i_hwdata[CFG_FRZ], i_hwdata[CFG_OFF]};
            if (wr && ph_addr == OFS_MASK) mask <= {29'h0, i_hwdata[2:0]};
            // Set wins over write-one-to-clear
            irq_st <= {29'h0, (irq_st[IRQ_W-1:0] &
                ~((wr && ph_addr == OFS_STATUS) ? i_hwdata[IRQ_W-1:0]
                : 3'h0)) | ev};
            if (next_pwr == CTD_OFF) lp_ack <= 1'b1;
            else if (pwr == CTD_WAKE && !stop_s2) lp_ack <= 1'b0;
            if (next_pwr == CTD_OFF) freeze_acknowledge <= 1'b0;
            else if (pwr == CTD_RUN) freeze_acknowledge <= cfg[CFG_FRZ];
            if (done_rep) last_done <= done.buf_idx;
        end
    end

    for (genvar b = 0; b < NBUF; b++) begin : g_buf
        wire hit = cmd_wr && cbuf == b;
        wire sent = done.valid && done.buf_idx == b;
        always_ff @(posedge i_mclk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                code[b] <= CODE_INACTIVE;
                abort_pend[b] <= 1'b0;
                deact[b] <= 1'b0;
            end else if (sent) begin
                abort_pend[b] <= 1'b0;
                deact[b] <= 1'b0;
                if (!deact[b]) code[b] <= CODE_INACTIVE;
            end else if (hit && !abort_pend[b]) begin
                case (op)
                    OP_WRITE: begin
                        code[b] <= ccode;
                    end
                    OP_ABORT: begin
                        abort_pend[b] <= code[b] == CODE_TX_DATA;
                        code[b] <= code[b] == CODE_TX_DATA ? code[b]
                            : CODE_ABORT;
                    end
                    OP_DEACT: begin
                        deact[b] <= code[b] == CODE_TX_DATA;
                        code[b] <= CODE_INACTIVE;
                    end
                    default: code[b] <= code[b];
                endcase
            end
        end

        // Pending abort locks the buffer's code until it sends
        a_abort_hold: assert property (@(posedge i_mclk)
            disable iff (!i_rst_n)
            abort_pend[b] && !sent |=> $stable(code[b]) && abort_pend[b])
            else $error("aborted buffer changed");

        a_deact_code: assert property (@(posedge i_mclk)
            disable iff (!i_rst_n)
            sent && deact[b] |=> $stable(code[b]) && !deact[b])
            else $error("deactivated buffer code updated");

        a_sent_idle: assert property (@(posedge i_mclk)
            disable iff (!i_rst_n)
            sent && !deact[b] |=> code[b] == CODE_INACTIVE)
            else $error("sent buffer not released");
    end

    a_off_requests: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (pwr == CTD_RUN && off_bit) |=> o_clk_stop_req)
        else $error("stop request not raised");

    a_ack_pair: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        lp_ack && pwr == CTD_OFF |-> !freeze_acknowledge && o_clk_stop_req)
        else $error("acks inconsistent");

    a_sent_clears: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        (done.valid && abort_pend[done.buf_idx])
        |=> !abort_pend[$past(i_tx_buf)])
        else $error("abort not released");

    a_deact_silent: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (done.valid && deact[done.buf_idx] && !irq_st[IRQ_TXDONE])
        |=> !irq_st[IRQ_TXDONE])
        else $error("event on deactivated buffer");

    a_txdone_flag: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        done_rep |=> irq_st[IRQ_TXDONE])
        else $error("transmit event lost");

    a_wake_drop: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (pwr == CTD_OFF && !off_bit) |=> !o_clk_stop_req)
        else $error("request not withdrawn");

    // Request stays up until the clock unit answers or software withdraws
    a_req_hold: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        pwr == CTD_REQ && !stop_s2 && off_bit |=> o_clk_stop_req)
        else $error("stop request dropped early");

    a_freeze_drop: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        pwr == CTD_REQ && stop_s2 |=> lp_ack && !freeze_acknowledge)
        else $error("acks not updated on clock stop");

    a_lp_ack_state: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        lp_ack |-> pwr == CTD_OFF || pwr == CTD_WAKE)
        else $error("low power ack outside off state");

    a_wake_hold: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        pwr == CTD_WAKE && stop_s2 |=> lp_ack)
        else $error("low power ack dropped before clocks resume");
endmodule // ctd_ctrl

// File: ctd_clk_model.sv
`timescale 1ns/100ps
module ctd_clk_model (
    input wire logic i_mclk, // System clock
    input wire logic i_rst_n, // Reset, active low
    input wire logic i_slow, // Answer slowly
    input wire logic i_req, // Clock stop request
    output logic o_stopped // Engine clocks halted
);
    int cnt;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 0;
            o_stopped <= 1'b0;
        end else if (o_stopped != i_req) begin
            cnt <= cnt + 1;
            if (cnt >= (i_slow ? 8 : 1)) begin
                o_stopped <= i_req;
                cnt <= 0;
            end
        end else begin
            cnt <= 0;
        end
    end
endmodule // ctd_clk_model

// File: testbench.sv
`timescale 1ns/100ps
`define CHK(n,e,a) begin comparisons++; if ((a)!==(e)) begin fails++; \
$display("ERROR %s exp %h got %h", n, e, a); end end
module testbench import ctd_pkg::*; ;
    logic clk = 0, rst_n = 0, hsel = 0, hw = 0, slow = 0, txd = 0;
    logic [11:0] ha = 0;
    logic [1:0] ht = 0;
    logic [2:0] hs = 0;
    logic [31:0] wd = 0, rdv;
    logic [3:0] txb = 0, b, k;
    wire [31:0] hrd;
    wire rdy, resp, req, irq, stp;
    int fails = 0, comparisons = 0, seed = 32'hf919, pend = 0;
    always #25 clk = ~clk;
    ctd_ctrl #(.NBUF(16)) i_dut (.i_mclk(clk), .i_rst_n(rst_n),
        .i_hsel(hsel), .i_haddr(ha), .i_htrans(ht), .i_hwrite(hw),
        .i_hsize(hs), .i_hwdata(wd), .i_hready(rdy), .o_hrdata(hrd),
        .o_hreadyout(rdy), .o_hresp(resp), .i_clk_stopped(stp),
        .i_tx_done(txd), .i_tx_buf(txb), .o_clk_stop_req(req), .o_irq(irq));
    ctd_clk_model i_clk (.i_mclk(clk), .i_rst_n(rst_n), .i_slow(slow),
        .i_req(req), .o_stopped(stp));
    task test_done;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task hold;
        int n;
        n = 0;
        do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 50);
        if (rdy !== 1'b1) begin fails++; test_done; end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1; ha <= a; ht <= HTRANS_NONSEQ; hw <= w; hs <= 3'h2;
        hold();
        hsel <= 0; ht <= 2'h0; wd <= d;
        hold();
        rdv = hrd;
    endtask
    task poll(input int bn, input logic v);
        int n;
        n = 0;
        do begin bus(0, OFS_EVENT, 0); n++; end
        while (rdv[bn] !== v && n < 40);
    endtask
    task done(input logic [3:0] bb);
        txd <= 1; txb <= bb;
        @(posedge clk);
        txd <= 0;
        @(posedge clk);
    endtask
    function automatic logic [31:0] cmd(logic [1:0] op, logic [3:0] bb,
        logic [3:0] c);
        return {20'h0, c, bb, 2'b00, op};
    endfunction
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        bus(0, OFS_STATUS, 0);
        `CHK("status", 32'h0, rdv)
        `CHK("irq", 1'b0, irq)
        slow <= $random(seed);
        bus(1, OFS_MASK, 32'h7);
        bus(1, OFS_CONFIG, 32'h2);
        poll(ST_FRZACK, 1);
        `CHK("freeze_acknowledge", 1'b1, rdv[ST_FRZACK])
        bus(1, OFS_CONFIG, 32'h3);
        poll(ST_LPACK, 1);
        `CHK("lp flags", 3'b101, rdv[4:2])
        `CHK("stop req", 1'b1, req)
        `CHK("stopped", 1'b1, stp)
        bus(1, OFS_MASK, 32'h0);
        bus(0, OFS_STATUS, 0);
        `CHK("lp event", 1'b1, rdv[IRQ_LPENTER])
        `CHK("irq masked", 1'b0, irq)
        bus(1, OFS_MASK, 32'h7);
        bus(1, OFS_CONFIG, 32'h0);
        poll(ST_LPACK, 0);
        `CHK("req off", 1'b0, rdv[ST_CLKREQ])
        `CHK("resumed", 1'b0, stp)
        bus(0, OFS_STATUS, 0);
        `CHK("lp exit", 3'b110, rdv[2:0])
        `CHK("irq set", 1'b1, irq)
        $display("test power end");
        b = $random(seed);
        k = b + 4'h1;
        bus(1, OFS_BUF_CMD, cmd(OP_WRITE, b, CODE_TX_DATA));
        bus(1, OFS_BUF_CMD, cmd(OP_ABORT, b, 4'h0));
        pend |= 1 << b;
        bus(1, OFS_BUF_CMD, cmd(OP_DEACT, b, 4'h0));
        bus(1, OFS_BUF_CMD, cmd(OP_WRITE, b, CODE_INACTIVE));
        bus(0, OFS_BUF_STATE, 0);
        `CHK("pending", pend, rdv)
        bus(1, OFS_BUF_CMD, cmd(OP_WRITE, k, CODE_TX_DATA));
        bus(1, OFS_BUF_CMD, cmd(OP_DEACT, k, 4'h0));
        bus(1, OFS_STATUS, 32'h7);
        done(k);
        bus(0, OFS_STATUS, 0);
        `CHK("deact flag", 3'b000, rdv[2:0])
        `CHK("irq idle", 1'b0, irq)
        done(b);
        pend &= ~(1 << b);
        bus(0, OFS_BUF_STATE, 0);
        `CHK("released", pend, rdv)
        bus(0, OFS_STATUS, 0);
        `CHK("tx flag", 1'b1, rdv[IRQ_TXDONE])
        bus(0, OFS_EVENT, 0);
        `CHK("done buf", b, rdv[3:0])
        bus(1, 12'h020, 32'hffff);
        bus(0, 12'h020, 0);
        `CHK("unmapped", 32'h0, rdv)
        $display("test buffers end");
        test_done;
    end
endmodule // testbench
